// file: hw/wsru_core.sv
// word shift and rotate unit with its AXI4-Lite register slave
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
module wsru_core (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic irq
);
	// ************************************************************
	// declarations
	// ************************************************************
	wsru_pkg::wsru_state_t state_reg;
	wsru_pkg::wsru_cmd_t cmd_reg, cmd_next;
	wsru_pkg::wsru_flags_t flags_reg;
	logic [23:0] lo_reg, hi_reg, lo_next, hi_next;
	logic [7:0] cnt_reg, aw_addr_reg;
	logic ovf_next, pair_op, step, finish, start, res_neg, res_zero;
	logic [1:0] int_stat_reg, int_mask_reg, int_set, bresp_reg, rresp_reg;
	logic irq_reg, aw_got_reg, w_got_reg, aw_got_next, w_got_next;
	logic [31:0] w_data_reg, rdata_reg, wr_val, rd_val;
	logic [3:0] w_strb_reg;
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic wr_fire, ar_fire, wr_ok, rd_ok, busy;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = dat[i*8 +: 8];
			end
		end
		return res;
	endfunction

	assign busy = (state_reg == wsru_pkg::WSRU_RUN);
	assign awready = awready_reg;
	assign wready = wready_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = arready_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign irq = irq_reg;

	// ************************************************************
	// write channel capture
	// ************************************************************
	assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
	assign aw_got_next = (awvalid && awready_reg) ? 1'b1 : (wr_fire ? 1'b0 : aw_got_reg);
	assign w_got_next = (wvalid && wready_reg) ? 1'b1 : (wr_fire ? 1'b0 : w_got_reg);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
		end else begin
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			awready_reg <= !aw_got_next;
			wready_reg <= !w_got_next;
			if (awvalid && awready_reg) begin
				aw_addr_reg <= awaddr;
			end
			if (wvalid && wready_reg) begin
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
			end
		end
	end

	// ************************************************************
	// write decode: a command or operand write while busy is refused
	// ************************************************************
	always_comb begin
		cmd_next = cmd_reg;
		wr_ok = 1'b0;
		wr_val = 32'h00000000;
		case (aw_addr_reg)
			wsru_pkg::ADDR_CMD: begin
				wr_val = merge({8'h00, cmd_reg}, w_data_reg, w_strb_reg);
				cmd_next = wr_val[23:0];
				wr_ok = !busy && (cmd_next.opcode >= wsru_pkg::OP_SHL_ARITH_SINGLE) &&
					(cmd_next.opcode <= wsru_pkg::OP_ROTR_PAIR);
			end
			wsru_pkg::ADDR_LO_WORD: begin
				wr_val = merge({8'h00, lo_reg}, w_data_reg, w_strb_reg);
				wr_ok = !busy;
			end
			wsru_pkg::ADDR_HI_WORD: begin
				wr_val = merge({8'h00, hi_reg}, w_data_reg, w_strb_reg);
				wr_ok = !busy;
			end
			wsru_pkg::ADDR_STATUS: begin
				wr_ok = 1'b1;
			end
			wsru_pkg::ADDR_INT_STAT, wsru_pkg::ADDR_INT_MASK: begin
				wr_val = w_data_reg;
				wr_ok = 1'b1;
			end
			default: begin
				wr_ok = 1'b0;
			end
		endcase
	end

	assign start = wr_fire && wr_ok && (aw_addr_reg == wsru_pkg::ADDR_CMD);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= wsru_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_ok ? wsru_pkg::RESP_OKAY : wsru_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// ************************************************************
	// read channel
	// ************************************************************
	assign ar_fire = arvalid && arready_reg;

	always_comb begin
		rd_ok = 1'b1;
		case (araddr)
			wsru_pkg::ADDR_CMD: rd_val = {8'h00, cmd_reg};
			wsru_pkg::ADDR_LO_WORD: rd_val = {8'h00, lo_reg};
			wsru_pkg::ADDR_HI_WORD: rd_val = {8'h00, hi_reg};
			wsru_pkg::ADDR_STATUS: rd_val = {27'h0, flags_reg, busy};
			wsru_pkg::ADDR_INT_STAT: rd_val = {30'h0, int_stat_reg};
			wsru_pkg::ADDR_INT_MASK: rd_val = {30'h0, int_mask_reg};
			default: begin
				rd_val = 32'h00000000;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= wsru_pkg::RESP_OKAY;
		end else if (ar_fire) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_val;
			rresp_reg <= rd_ok ? wsru_pkg::RESP_OKAY : wsru_pkg::RESP_SLVERR;
		end else if (rvalid_reg && rready) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end else if (!rvalid_reg) begin
			arready_reg <= 1'b1;
		end
	end

	// ************************************************************
	// one shift step per clock; a count of 255 takes 255 steps and stays busy 256 cycles
	// ************************************************************
	assign pair_op = (cmd_reg.opcode >= wsru_pkg::OP_SHL_ARITH_PAIR);
	assign step = busy && (cnt_reg != 8'h00);
	assign finish = busy && (cnt_reg == 8'h00);

	always_comb begin
		lo_next = lo_reg;
		hi_next = hi_reg;
		ovf_next = 1'b0;
		case (cmd_reg.opcode)
			wsru_pkg::OP_SHL_ARITH_SINGLE: lo_next = {lo_reg[23], lo_reg[21:0], 1'b0};
			wsru_pkg::OP_SHR_ARITH_SINGLE: lo_next = {lo_reg[23], lo_reg[23], lo_reg[22:1]};
			wsru_pkg::OP_SHL_LOGIC_SINGLE: lo_next = {lo_reg[22:0], 1'b0};
			wsru_pkg::OP_SHR_LOGIC_SINGLE: lo_next = {1'b0, lo_reg[23:1]};
			wsru_pkg::OP_ROTL_SINGLE: lo_next = {lo_reg[22:0], lo_reg[23]};
			wsru_pkg::OP_ROTR_SINGLE: lo_next = {lo_reg[0], lo_reg[23:1]};
			wsru_pkg::OP_SHL_ARITH_PAIR: begin
				hi_next = {hi_reg[23], hi_reg[21:0], lo_reg[22]};
				lo_next = {lo_reg[23], lo_reg[21:0], 1'b0};
				ovf_next = hi_reg[22] ^ hi_reg[23];
			end
			wsru_pkg::OP_SHR_ARITH_PAIR: begin
				hi_next = {hi_reg[23], hi_reg[23], hi_reg[22:1]};
				lo_next = {lo_reg[23], hi_reg[0], lo_reg[22:1]};
			end
			wsru_pkg::OP_SHL_LOGIC_PAIR: begin
				{hi_next, lo_next} = {hi_reg[22:0], lo_reg, 1'b0};
				ovf_next = hi_reg[22] ^ hi_reg[23];
			end
			wsru_pkg::OP_SHR_LOGIC_PAIR: {hi_next, lo_next} = {1'b0, hi_reg, lo_reg[23:1]};
			wsru_pkg::OP_ROTL_PAIR: begin
				hi_next = {hi_reg[22:0], lo_reg[23]};
				lo_next = {lo_reg[22:0], hi_reg[23]};
			end
			wsru_pkg::OP_ROTR_PAIR: begin
				hi_next = {lo_reg[0], hi_reg[23:1]};
				lo_next = {hi_reg[0], lo_reg[23:1]};
			end
			default: begin
				lo_next = lo_reg;
			end
		endcase
	end

	// sign bit position is the only thing arithmetic and logical variants differ on
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lo_reg <= wsru_pkg::WORD_RESET;
			hi_reg <= wsru_pkg::WORD_RESET;
		end else if (step) begin
			lo_reg <= lo_next;
			hi_reg <= hi_next;
		end else if (wr_fire && wr_ok && aw_addr_reg == wsru_pkg::ADDR_LO_WORD) begin
			lo_reg <= wr_val[23:0];
		end else if (wr_fire && wr_ok && aw_addr_reg == wsru_pkg::ADDR_HI_WORD) begin
			hi_reg <= wr_val[23:0];
		end
	end
	property p_arith_sign;
		@(posedge aclk) disable iff (!aresetn)
		step && cmd_reg.opcode == wsru_pkg::OP_SHR_ARITH_SINGLE |=> lo_reg[23] == $past(lo_reg[23]);
	endproperty
	a_arith_sign: assert property (p_arith_sign) else $error("sign bit changed");
	property p_single_hi_kept;
		@(posedge aclk) disable iff (!aresetn)
		step && cmd_reg.opcode == wsru_pkg::OP_SHL_ARITH_SINGLE |=> $stable(hi_reg);
	endproperty
	a_single_hi_kept: assert property (p_single_hi_kept) else $error("hi_word touched");
	property p_rotl_single;
		@(posedge aclk) disable iff (!aresetn)
		step && cmd_reg.opcode == wsru_pkg::OP_ROTL_SINGLE |=>
			lo_reg == {$past(lo_reg[22:0]), $past(lo_reg[23])};
	endproperty
	a_rotl_single: assert property (p_rotl_single) else $error("rotate lost a bit");
	property p_rad_bypass;
		@(posedge aclk) disable iff (!aresetn)
		step && cmd_reg.opcode == wsru_pkg::OP_SHR_ARITH_PAIR |=>
			lo_reg[23] == $past(lo_reg[23]) && lo_reg[22] == $past(hi_reg[0]);
	endproperty
	a_rad_bypass: assert property (p_rad_bypass) else $error("pair right arith wrong");
	property p_rotr_pair;
		@(posedge aclk) disable iff (!aresetn)
		step && cmd_reg.opcode == wsru_pkg::OP_ROTR_PAIR |=>
			hi_reg[23] == $past(lo_reg[0]) && lo_reg[23] == $past(hi_reg[0]);
	endproperty
	a_rotr_pair: assert property (p_rotr_pair) else $error("pair rotate right wrong");
	property p_logic_fill;
		@(posedge aclk) disable iff (!aresetn)
		step && cmd_reg.opcode == wsru_pkg::OP_SHR_LOGIC_SINGLE |=> !lo_reg[23];
	endproperty
	a_logic_fill: assert property (p_logic_fill) else $error("right logical not zero filled");

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= wsru_pkg::WSRU_IDLE;
			cmd_reg <= '0;
			cnt_reg <= wsru_pkg::COUNT_RESET;
		end else begin
			case (state_reg)
				wsru_pkg::WSRU_IDLE: begin
					if (start) begin
						cmd_reg <= cmd_next;
						cnt_reg <= cmd_next.count;
						state_reg <= wsru_pkg::WSRU_RUN;
					end
				end
				wsru_pkg::WSRU_RUN: begin
					if (step) begin
						cnt_reg <= cnt_reg - 8'h01;
					end else begin
						state_reg <= wsru_pkg::WSRU_IDLE;
					end
				end
				default: state_reg <= wsru_pkg::WSRU_IDLE;
			endcase
		end
	end
	property p_count_down;
		@(posedge aclk) disable iff (!aresetn)
		start |=> busy && cnt_reg == $past(cmd_next.count);
	endproperty
	a_count_down: assert property (p_count_down) else $error("count not loaded");
	property p_zero_count;
		@(posedge aclk) disable iff (!aresetn)
		start && cmd_next.count == 8'h00 |=> busy ##1 !busy && $stable(lo_reg) && $stable(hi_reg);
	endproperty
	a_zero_count: assert property (p_zero_count) else $error("zero count moved data");

	// ************************************************************
	// condition flags
	// ************************************************************
	assign res_neg = pair_op ? hi_reg[23] : lo_reg[23];
	assign res_zero = pair_op ? ({hi_reg, lo_reg} == 48'h000000000000) : (lo_reg == 24'h000000);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_reg <= '0;
		end else if (start) begin
			flags_reg.ovf <= 1'b0;
		end else if (step && ovf_next) begin
			flags_reg.ovf <= 1'b1;
		end else if (finish) begin
			flags_reg.neg <= res_neg;
			flags_reg.zero <= res_zero;
			flags_reg.pos <= !res_neg && !res_zero;
		end
	end
	property p_done_flags;
		@(posedge aclk) disable iff (!aresetn)
		finish |=> !busy && flags_reg.zero == $past(res_zero) && int_stat_reg[0];
	endproperty
	a_done_flags: assert property (p_done_flags) else $error("flags wrong at end");
	property p_ovf;
		@(posedge aclk) disable iff (!aresetn)
		step && cmd_reg.opcode == wsru_pkg::OP_SHL_LOGIC_PAIR && hi_reg[22] != hi_reg[23]
			|=> flags_reg.ovf;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow missed");

	// ************************************************************
	// interrupts: set wins over a write-one clear
	// ************************************************************
	assign int_set = {finish && flags_reg.ovf, finish};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_stat_reg <= wsru_pkg::INT_RESET;
			int_mask_reg <= wsru_pkg::INT_RESET;
			irq_reg <= 1'b0;
		end else begin
			if (wr_fire && aw_addr_reg == wsru_pkg::ADDR_INT_STAT) begin
				int_stat_reg <= (int_stat_reg & ~wr_val[1:0]) | int_set;
			end else begin
				int_stat_reg <= int_stat_reg | int_set;
			end
			if (wr_fire && aw_addr_reg == wsru_pkg::ADDR_INT_MASK) begin
				int_mask_reg <= wr_val[1:0];
			end
			irq_reg <= |(int_stat_reg & int_mask_reg);
		end
	end
endmodule

// file: shared/wsru_pkg.sv
// constants and carrier types of the word shift and rotate unit
package wsru_pkg;
	// ************************************************************
	// register map, byte addresses
	// ************************************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_LO_WORD = 8'h04;
	localparam logic [7:0] ADDR_HI_WORD = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_INT_STAT = 8'h10;
	localparam logic [7:0] ADDR_INT_MASK = 8'h14;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ************************************************************
	// word geometry and reset values
	// ************************************************************
	localparam int WORD_W = 24;
	localparam int SIGN_BIT = 23;
	localparam logic [23:0] WORD_RESET = 24'h000000;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [1:0] INT_RESET = 2'h0;
	localparam int INT_DONE_BIT = 0;
	localparam int INT_OVF_BIT = 1;
	// ************************************************************
	// operation codes, bits 23-12 of the command word
	// ************************************************************
	localparam logic [11:0] OP_SHL_ARITH_SINGLE = 12'h020;
	localparam logic [11:0] OP_SHR_ARITH_SINGLE = 12'h021;
	localparam logic [11:0] OP_SHL_LOGIC_SINGLE = 12'h022;
	localparam logic [11:0] OP_SHR_LOGIC_SINGLE = 12'h023;
	localparam logic [11:0] OP_ROTL_SINGLE = 12'h024;
	localparam logic [11:0] OP_ROTR_SINGLE = 12'h025;
	localparam logic [11:0] OP_SHL_ARITH_PAIR = 12'h026;
	localparam logic [11:0] OP_SHR_ARITH_PAIR = 12'h027;
	localparam logic [11:0] OP_SHL_LOGIC_PAIR = 12'h028;
	localparam logic [11:0] OP_SHR_LOGIC_PAIR = 12'h029;
	localparam logic [11:0] OP_ROTL_PAIR = 12'h02A;
	localparam logic [11:0] OP_ROTR_PAIR = 12'h02B;
	// ************************************************************
	// carrier types
	// ************************************************************
	typedef struct packed {
		logic [11:0] opcode;
		logic [3:0] rsvd;
		logic [7:0] count;
	} wsru_cmd_t;
	typedef struct packed {
		logic ovf;
		logic zero;
		logic neg;
		logic pos;
	} wsru_flags_t;
	typedef enum logic {WSRU_IDLE, WSRU_RUN} wsru_state_t;
endpackage

// file: dv/wsru_host.sv
// bus master model standing in for the cpu decode and sequencing side
`timescale 1ns/10ps
module wsru_host (
	input wire logic aclk,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	// ********************
	// idle bus
	// ********************
	initial begin
		awaddr = 8'h00;
		awvalid = 1'h0;
		wdata = 32'h0;
		wstrb = 4'h0;
		wvalid = 1'h0;
		bready = 1'h0;
		araddr = 8'h00;
		arvalid = 1'h0;
		rready = 1'h0;
	end
	// ********************
	// transfers
	// ********************
	// released payloads are inverted so a slave that samples late sees garbage
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic pend_aw;
		logic pend_w;
		resp = 2'h1;
		pend_aw = 1'h1;
		pend_w = 1'h1;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'h1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'h1;
		bready <= 1'h1;
		// no limit of its own: the bench watchdog ends a hang
		forever begin
			@(posedge aclk);
			if (pend_aw && awready) begin
				awvalid <= 1'h0;
				awaddr <= ~a;
				pend_aw = 1'h0;
			end
			if (pend_w && wready) begin
				wvalid <= 1'h0;
				wdata <= ~d;
				pend_w = 1'h0;
			end
			if (!pend_aw && !pend_w && bvalid) begin
				resp = bresp;
				bready <= 1'h0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic pend;
		resp = 2'h1;
		d = 32'h0;
		pend = 1'h1;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (pend && arready) begin
				arvalid <= 1'h0;
				araddr <= ~a;
				pend = 1'h0;
			end
			if (!pend && rvalid) begin
				d = rdata;
				resp = rresp;
				rready <= 1'h0;
				break;
			end
		end
	endtask
endmodule

// file: dv/wsru_bench.sv
// self-checking bench of the word shift and rotate unit
`timescale 1ns/10ps
module wsru_bench;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r, msk;
	logic [31:0] d;
	logic [51:0] e;
	int error_cnt = 0;
	int tests_run = 0;
	logic [7:0] regs [4] = '{wsru_pkg::ADDR_LO_WORD, wsru_pkg::ADDR_HI_WORD,
		wsru_pkg::ADDR_INT_STAT, wsru_pkg::ADDR_INT_MASK};
	logic [7:0] cnts [6] = '{8'h00, 8'h01, 8'h05, 8'h18, 8'h30, 8'hFF};
	wsru_core DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .irq(irq));
	wsru_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready));
	// ********************
	// clock and watchdog
	// ********************
	initial begin
		aclk = 1'h0;
		forever #20 aclk = ~aclk;
	end
	// longest run is about 7k cycles, so 80k leaves room without hiding a hang
	initial begin
		#(80000 * 40);
		error_cnt++;
		end_sim();
	end
	// ********************
	// helpers
	// ********************
	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// stepwise reference, one bit per step as the hardware does it
	function automatic logic [51:0] model(input logic [11:0] op, input logic [7:0] n,
			input logic [23:0] hi, input logic [23:0] lo);
		logic [47:0] v;
		logic ovf;
		logic pair;
		wsru_pkg::wsru_flags_t f;
		v = {hi, lo};
		ovf = 1'h0;
		pair = op >= wsru_pkg::OP_SHL_ARITH_PAIR;
		for (int i = 0; i < n; i++) begin
			if (op == wsru_pkg::OP_SHL_ARITH_PAIR || op == wsru_pkg::OP_SHL_LOGIC_PAIR)
				ovf = ovf | (v[46] ^ v[47]);
			case (op)
				wsru_pkg::OP_SHL_ARITH_SINGLE: v[22:0] = {v[21:0], 1'h0};
				wsru_pkg::OP_SHR_ARITH_SINGLE: v[22:0] = {v[23], v[22:1]};
				wsru_pkg::OP_SHL_LOGIC_SINGLE: v[23:0] = {v[22:0], 1'h0};
				wsru_pkg::OP_SHR_LOGIC_SINGLE: v[23:0] = {1'h0, v[23:1]};
				wsru_pkg::OP_ROTL_SINGLE: v[23:0] = {v[22:0], v[23]};
				wsru_pkg::OP_ROTR_SINGLE: v[23:0] = {v[0], v[23:1]};
				wsru_pkg::OP_SHL_ARITH_PAIR: v = {v[47], v[45:24], v[22], v[23], v[21:0], 1'h0};
				wsru_pkg::OP_SHR_ARITH_PAIR: v = {v[47], v[47], v[46:25], v[23], v[24], v[22:1]};
				wsru_pkg::OP_SHL_LOGIC_PAIR: v = {v[46:0], 1'h0};
				wsru_pkg::OP_SHR_LOGIC_PAIR: v = {1'h0, v[47:1]};
				wsru_pkg::OP_ROTL_PAIR: v = {v[46:0], v[47]};
				default: v = {v[0], v[47:1]};
			endcase
		end
		f.ovf = ovf;
		f.zero = pair ? v == 48'h0 : v[23:0] == 24'h0;
		f.neg = pair ? v[47] : v[23];
		f.pos = !f.zero && !f.neg;
		return {f, v};
	endfunction
	task automatic start(input logic [11:0] op, input logic [7:0] n, input logic [23:0] hi,
			input logic [23:0] lo, output logic [51:0] ex);
		logic [1:0] rs;
		ex = model(op, n, hi, lo);
		host.wr(wsru_pkg::ADDR_LO_WORD, {8'h00, lo}, rs);
		host.wr(wsru_pkg::ADDR_HI_WORD, {8'h00, hi}, rs);
		host.wr(wsru_pkg::ADDR_CMD, {8'h00, op, 4'h0, n}, rs);
		chk({30'h0, rs}, 32'h0);
	endtask
	task automatic wait_done(input logic [51:0] ex);
		logic [31:0] dd;
		logic [1:0] rs;
		dd = 32'h1;
		for (int t = 0; t < 400 && dd[0] === 1'h1; t++) begin
			host.rd(wsru_pkg::ADDR_STATUS, dd, rs);
		end
		chk(dd, {27'h0, ex[51:48], 1'h0});
		host.rd(wsru_pkg::ADDR_LO_WORD, dd, rs);
		chk(dd, {8'h00, ex[23:0]});
		host.rd(wsru_pkg::ADDR_HI_WORD, dd, rs);
		chk(dd, {8'h00, ex[47:24]});
		host.rd(wsru_pkg::ADDR_INT_STAT, dd, rs);
		chk(dd, {30'h0, ex[51], 1'h1});
		chk({31'h0, irq}, {31'h0, |(msk & {ex[51], 1'h1})});
		host.wr(wsru_pkg::ADDR_INT_STAT, 32'h3, rs);
		host.rd(wsru_pkg::ADDR_INT_STAT, dd, rs);
		chk(dd, 32'h0);
		chk({31'h0, irq}, 32'h0);
	endtask
	// ********************
	// tests
	// ********************
	initial begin
		aresetn = 1'h0;
		msk = 2'h0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		foreach (regs[k]) begin
			host.rd(regs[k], d, r);
			chk(d, 32'h0);
		end
		// every code, boundary counts, all four mask settings
		for (int i = 0; i < 12; i++) begin
			msk = 2'(i);
			host.wr(wsru_pkg::ADDR_INT_MASK, {30'h0, msk}, r);
			host.rd(wsru_pkg::ADDR_INT_MASK, d, r);
			chk(d, {30'h0, msk});
			foreach (cnts[j]) begin
				start(wsru_pkg::OP_SHL_ARITH_SINGLE + 12'(i), cnts[j],
					24'h6B1D42 ^ {3'(j), 21'h0}, 24'h93E07C ^ {8'(i), 16'h0}, e);
				wait_done(e);
			end
		end
		// writes during a long operation are refused and leave the words alone
		start(wsru_pkg::OP_ROTR_SINGLE, 8'hFF, 24'h123456, 24'h89ABCD, e);
		host.wr(wsru_pkg::ADDR_CMD, {8'h00, wsru_pkg::OP_ROTL_SINGLE, 12'h001}, r);
		chk({30'h0, r}, {30'h0, wsru_pkg::RESP_SLVERR});
		host.wr(wsru_pkg::ADDR_LO_WORD, 32'h0, r);
		chk({30'h0, r}, {30'h0, wsru_pkg::RESP_SLVERR});
		wait_done(e);
		host.wr(wsru_pkg::ADDR_CMD, {8'h00, 12'h02C, 12'h001}, r);
		chk({30'h0, r}, {30'h0, wsru_pkg::RESP_SLVERR});
		host.wr(wsru_pkg::ADDR_CMD, {8'h00, 12'h01F, 12'h001}, r);
		chk({30'h0, r}, {30'h0, wsru_pkg::RESP_SLVERR});
		host.wr(8'h18, 32'h5, r);
		chk({30'h0, r}, {30'h0, wsru_pkg::RESP_SLVERR});
		host.rd(8'h18, d, r);
		chk({d[29:0], r}, {30'h0, wsru_pkg::RESP_SLVERR});
		end_sim();
	end
endmodule
